// [common/crb_pkg.sv]
// Constants and state types of the CAN receive routing and overflow block
package crb_pkg;

  localparam int NUM_BUF = 32;
  localparam int HALF_BUF = 16;
  localparam int FIELD_W = 4;
  localparam int REG_W = 16;

  // Byte addresses on the register bus
  localparam logic [4:0] OFF_PTR = 5'h00;
  localparam logic [4:0] OFF_OVF_LO = 5'h04;
  localparam logic [4:0] OFF_OVF_HI = 5'h08;
  localparam logic [4:0] OFF_IRQ_STS = 5'h0C;
  localparam logic [4:0] OFF_IRQ_MSK = 5'h10;

  // Target field positions in the pointer register
  localparam int F8_LSB = 0;
  localparam int F9_LSB = 4;
  localparam int F10_LSB = 8;
  localparam int F11_LSB = 12;

  // Target code meaning the receive FIFO
  localparam logic [3:0] TGT_FIFO = 4'hF;

  // Interrupt status and mask bit positions
  localparam int IRQ_W = 2;
  localparam int IRQ_OVF_LO = 0;
  localparam int IRQ_OVF_HI = 1;

  // Values after reset
  localparam logic [15:0] RST_PTR = 16'h0000;
  localparam logic [31:0] RST_OVF = 32'h0000_0000;
  localparam logic [1:0] RST_IRQ = 2'h0;
  localparam logic [31:0] RST_RDATA = 32'h0000_0000;

  typedef struct packed {
    logic [15:0] ptr;
    logic [31:0] ovf;
    logic [1:0] sts;
    logic [1:0] msk;
    logic ack;
    logic [31:0] rdata;
    logic rt_vld;
    logic rt_fifo;
    logic [3:0] rt_buf;
  } crb_state_t;

endpackage

// [core/crb_top.sv]
// Receive target routing for filters 8..11 and receive buffer overflow flags
//
// Chosen here: the register addresses and the Avalon-MM slave port.
`timescale 1ns/10ps
module crb_top #(
  parameter int ADDR_W = 5
) (
  input wire logic clk,
  input wire logic nrst,
  // Avalon-MM slave
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Filter hit from acceptance logic
  input wire logic hit_valid,
  input wire logic [1:0] hit_filter,
  // Routing decision
  output logic route_valid,
  output logic route_to_fifo,
  output logic [3:0] route_buf,
  // Buffer write attempt and fullness
  input wire logic buf_wr_req,
  input wire logic [4:0] buf_wr_idx,
  input wire logic [31:0] buf_full,
  // Interrupt
  output logic irq
);

  localparam int IRQ_W_C = crb_pkg::IRQ_W;
  localparam int NFLT = 4;

  generate
    if (ADDR_W < 5) begin : g_chk
      $error("crb_top: ADDR_W must be at least 5");
    end

    // Buffer and register widths are fixed by the ports
    if (crb_pkg::NUM_BUF != 32) begin : g_chk_nbuf
      $error("crb_top: NUM_BUF must match the 32 buffer ports");
    end

    if (crb_pkg::HALF_BUF * 2 != crb_pkg::NUM_BUF) begin : g_chk_half
      $error("crb_top: HALF_BUF must be half of NUM_BUF");
    end

    if (crb_pkg::REG_W != 16) begin : g_chk_regw
      $error("crb_top: REG_W must be 16");
    end

    if (crb_pkg::HALF_BUF != crb_pkg::REG_W) begin : g_chk_bank
      $error("crb_top: each flag register must hold HALF_BUF flags");
    end

    if (crb_pkg::FIELD_W != 4) begin : g_chk_fw
      $error("crb_top: FIELD_W must be 4");
    end

    if (NFLT * crb_pkg::FIELD_W != crb_pkg::REG_W) begin : g_chk_nflt
      $error("crb_top: four target fields must fill the pointer register");
    end

    // Target field layout in the pointer register
    if (crb_pkg::F8_LSB != 0) begin : g_chk_f8
      $error("crb_top: filter 8 field must start at bit 0");
    end

    if (crb_pkg::F9_LSB != crb_pkg::FIELD_W) begin : g_chk_f9
      $error("crb_top: filter 9 field must follow filter 8");
    end

    if (crb_pkg::F10_LSB != 2 * crb_pkg::FIELD_W) begin : g_chk_f10
      $error("crb_top: filter 10 field must follow filter 9");
    end

    if (crb_pkg::F11_LSB != 3 * crb_pkg::FIELD_W) begin : g_chk_f11
      $error("crb_top: filter 11 field must follow filter 10");
    end

    if (crb_pkg::TGT_FIFO != 4'hF) begin : g_chk_fifo
      $error("crb_top: FIFO target code must be all ones");
    end

    // Interrupt bits follow the two flag registers
    if (crb_pkg::IRQ_W != 2) begin : g_chk_irqw
      $error("crb_top: IRQ_W must be 2");
    end

    if (crb_pkg::IRQ_OVF_LO != 0) begin : g_chk_irqlo
      $error("crb_top: low flag register event must be bit 0");
    end

    if (crb_pkg::IRQ_OVF_HI != 1) begin : g_chk_irqhi
      $error("crb_top: high flag register event must be bit 1");
    end

    // Offsets word aligned and ascending
    if ((crb_pkg::OFF_PTR & 5'h03) != 5'h00) begin : g_chk_aptr
      $error("crb_top: pointer offset not word aligned");
    end

    if ((crb_pkg::OFF_OVF_LO & 5'h03) != 5'h00) begin : g_chk_alo
      $error("crb_top: low flag offset not word aligned");
    end

    if ((crb_pkg::OFF_OVF_HI & 5'h03) != 5'h00) begin : g_chk_ahi
      $error("crb_top: high flag offset not word aligned");
    end

    if ((crb_pkg::OFF_IRQ_STS & 5'h03) != 5'h00) begin : g_chk_asts
      $error("crb_top: status offset not word aligned");
    end

    if ((crb_pkg::OFF_IRQ_MSK & 5'h03) != 5'h00) begin : g_chk_amsk
      $error("crb_top: mask offset not word aligned");
    end

    if (crb_pkg::OFF_OVF_LO <= crb_pkg::OFF_PTR) begin : g_chk_o1
      $error("crb_top: offsets must ascend");
    end

    if (crb_pkg::OFF_OVF_HI <= crb_pkg::OFF_OVF_LO) begin : g_chk_o2
      $error("crb_top: offsets must ascend");
    end

    if (crb_pkg::OFF_IRQ_STS <= crb_pkg::OFF_OVF_HI) begin : g_chk_o3
      $error("crb_top: offsets must ascend");
    end

    if (crb_pkg::OFF_IRQ_MSK <= crb_pkg::OFF_IRQ_STS) begin : g_chk_o4
      $error("crb_top: offsets must ascend");
    end
  endgenerate

  crb_pkg::crb_state_t s_q;
  crb_pkg::crb_state_t s_d;

  logic [31:0] ovf_set;
  logic [31:0] ovf_clr;
  logic [IRQ_W_C-1:0] irq_ev;

  logic req;
  logic acc;
  logic acc_wr;
  logic acc_rd;
  logic [4:0] addr;
  logic [15:0] wmask;
  logic [15:0] wdat;
  logic [3:0] sel_field;
  logic sel_fifo;

  // Register decodes of the bus address
  logic sel_ptr;
  logic sel_ovf_lo;
  logic sel_ovf_hi;
  logic sel_sts;
  logic sel_msk;

  // Target field and FIFO decode of each filter
  logic [NFLT-1:0][3:0] tgt_field;
  logic [NFLT-1:0] tgt_fifo;

  // Pointer value after a byte-lane write
  logic [15:0] ptr_wr;

  // Read value of each register
  logic [31:0] rd_ptr;
  logic [31:0] rd_ovf_lo;
  logic [31:0] rd_ovf_hi;
  logic [31:0] rd_sts;
  logic [31:0] rd_msk;
  logic [31:0] rd_word;

  assign addr = avs_address[4:0];
  assign req = avs_read | avs_write;

  // Answer one cycle after the request is seen
  assign avs_waitrequest = req & ~s_q.ack;

  // Edge at which a held request is served
  assign acc = req & s_q.ack;
  assign acc_wr = acc & avs_write;
  assign acc_rd = acc & avs_read;

  assign wmask = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  assign wdat = avs_writedata[15:0];

  assign sel_ptr = (addr == crb_pkg::OFF_PTR);
  assign sel_ovf_lo = (addr == crb_pkg::OFF_OVF_LO);
  assign sel_ovf_hi = (addr == crb_pkg::OFF_OVF_HI);
  assign sel_sts = (addr == crb_pkg::OFF_IRQ_STS);
  assign sel_msk = (addr == crb_pkg::OFF_IRQ_MSK);

  // Pointer write, each byte lane under its own byte enable
  genvar bl;
  generate
    for (bl = 0; bl < 2; bl++) begin : g_lane
      assign ptr_wr[bl*8 +: 8] = avs_byteenable[bl] ? wdat[bl*8 +: 8] : s_q.ptr[bl*8 +: 8];
    end
  endgenerate

  // Per-buffer overflow detection and software clear
  genvar gi;
  generate
    for (gi = 0; gi < crb_pkg::NUM_BUF; gi++) begin : g_buf
      // Write attempt into a still full buffer
      assign ovf_set[gi] = buf_wr_req
                           & (buf_wr_idx == 5'(gi))
                           & buf_full[gi];
      if (gi < crb_pkg::HALF_BUF) begin : g_lo
        // Only a written zero in an enabled lane clears
        assign ovf_clr[gi] = acc_wr
                             & sel_ovf_lo
                             & wmask[gi]
                             & ~wdat[gi];
      end else begin : g_hi
        assign ovf_clr[gi] = acc_wr
                             & sel_ovf_hi
                             & wmask[gi-crb_pkg::HALF_BUF]
                             & ~wdat[gi-crb_pkg::HALF_BUF];
      end
    end
  endgenerate

  // One interrupt event per flag register
  genvar gg;
  generate
    for (gg = 0; gg < IRQ_W_C; gg++) begin : g_irq
      assign irq_ev[gg] = |ovf_set[gg*crb_pkg::HALF_BUF +: crb_pkg::HALF_BUF];
    end
  endgenerate

  // Each filter owns one field of the pointer register
  genvar fi;
  generate
    for (fi = 0; fi < NFLT; fi++) begin : g_flt
      assign tgt_field[fi] = s_q.ptr[fi*crb_pkg::FIELD_W +: crb_pkg::FIELD_W];
      assign tgt_fifo[fi] = (tgt_field[fi] == crb_pkg::TGT_FIFO);
    end
  endgenerate

  // Field of the filter that was hit
  assign sel_field = tgt_field[hit_filter];
  assign sel_fifo = tgt_fifo[hit_filter];

  // Read value of each register, unused upper bits zero
  assign rd_ptr = {16'h0000, s_q.ptr};
  assign rd_ovf_lo = {16'h0000, s_q.ovf[15:0]};
  assign rd_ovf_hi = {16'h0000, s_q.ovf[31:16]};
  assign rd_sts = {30'h0000_0000, s_q.sts};
  assign rd_msk = {30'h0000_0000, s_q.msk};

  // Unmapped offsets in avs_address[4:0] read zero; address bits above bit 4 are not decoded
  always_comb begin
    rd_word = 32'h0000_0000;
    case (addr)
      crb_pkg::OFF_PTR: begin
        rd_word = rd_ptr;
      end
      crb_pkg::OFF_OVF_LO: begin
        rd_word = rd_ovf_lo;
      end
      crb_pkg::OFF_OVF_HI: begin
        rd_word = rd_ovf_hi;
      end
      crb_pkg::OFF_IRQ_STS: begin
        rd_word = rd_sts;
      end
      crb_pkg::OFF_IRQ_MSK: begin
        rd_word = rd_msk;
      end
      default: begin
        rd_word = 32'h0000_0000;
      end
    endcase
  end

  always_comb begin
    s_d = s_q;

    // Bus handshake
    s_d.ack = req & ~s_q.ack;

    // Pointer register write with byte lanes
    if (acc_wr && sel_ptr) begin
      s_d.ptr = ptr_wr;
    end

    // Interrupt mask write
    if (acc_wr && sel_msk && avs_byteenable[0]) begin
      s_d.msk = avs_writedata[IRQ_W_C-1:0];
    end

    // Set takes priority over clear
    s_d.ovf = (s_q.ovf & ~ovf_clr) | ovf_set;

    // Status clears on read, new events still land
    if (acc_rd && sel_sts) begin
      s_d.sts = irq_ev;
    end else begin
      s_d.sts = s_q.sts | irq_ev;
    end

    // Read data captured while waitrequest is high
    s_d.rdata = 32'h0000_0000;
    if (avs_read && !s_q.ack) begin
      s_d.rdata = rd_word;
    end else if (acc_rd) begin
      s_d.rdata = s_q.rdata;
    end

    // Route decision one cycle after the hit
    s_d.rt_vld = hit_valid;
    if (hit_valid) begin
      if (sel_fifo) begin
        s_d.rt_fifo = 1'b1;
        s_d.rt_buf = 4'h0;
      end else begin
        s_d.rt_fifo = 1'b0;
        s_d.rt_buf = sel_field;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_q.ptr <= crb_pkg::RST_PTR;
      s_q.ovf <= crb_pkg::RST_OVF;
      s_q.sts <= crb_pkg::RST_IRQ;
      s_q.msk <= crb_pkg::RST_IRQ;
      s_q.ack <= 1'b0;
      s_q.rdata <= crb_pkg::RST_RDATA;
      s_q.rt_vld <= 1'b0;
      s_q.rt_fifo <= 1'b0;
      s_q.rt_buf <= 4'h0;
    end else begin
      s_q <= s_d;
    end
  end

  assign avs_readdata = s_q.rdata;
  assign route_valid = s_q.rt_vld;
  assign route_to_fifo = s_q.rt_fifo;
  assign route_buf = s_q.rt_buf;
  assign irq = |(s_q.sts & s_q.msk);

endmodule

// [bench/crb_checker.sv]
// Port assertions for the routing block
`timescale 1ns/10ps
module crb_checker #(
  parameter int ADDR_W = 5
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic hit_valid,
  input wire logic route_valid,
  input wire logic route_to_fifo,
  input wire logic buf_wr_req,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic [31:0] buf_full,
  input wire logic [3:0] route_buf,
  input wire logic [4:0] buf_wr_idx
);
  logic ev, w, c, rl, rh, seen_q;
  assign ev = buf_wr_req && buf_full[buf_wr_idx];
  assign w = avs_write && !avs_waitrequest;
  assign c = w && avs_address == crb_pkg::OFF_OVF_LO && avs_byteenable[1:0] == 2'h3 && avs_writedata[15:0] == 16'h0;
  assign rl = avs_read && avs_waitrequest && avs_address == crb_pkg::OFF_OVF_LO;
  assign rh = avs_read && avs_waitrequest && avs_address == crb_pkg::OFF_OVF_HI;
  always_ff @(posedge clk or negedge nrst)
    if (!nrst) seen_q <= 1'b0;
    else if (ev) seen_q <= 1'b1;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence s_l; !w ##1 rl; endsequence
  sequence s_h; !w ##1 rh; endsequence
  AST_PULSE: assert property (route_valid == $past(hit_valid)) else $error("pulse");
  AST_FIFO: assert property (route_to_fifo |-> route_buf == 4'h0) else $error("fifo");
  AST_WAIT: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest) else $error("wait");
  AST_ZERO: assert property (rl && !seen_q |=> avs_readdata[15:0] == 16'h0) else $error("zero");
  AST_LO: assert property (ev && !buf_wr_idx[4] ##1 s_l |=> avs_readdata[$past(buf_wr_idx, 3)]) else $error("lo");
  AST_HI: assert property (ev && buf_wr_idx[4] ##1 s_h |=> avs_readdata[$past(buf_wr_idx, 3) - 5'h10]) else $error("hi");
  AST_CLR: assert property (c && !ev ##1 (!buf_wr_req throughout s_l) |=> avs_readdata[15:0] == 16'h0) else $error("clr");
  AST_WIN: assert property (ev && c && !buf_wr_idx[4] ##1 s_l |=> avs_readdata[$past(buf_wr_idx, 3)]) else $error("win");
endmodule
bind crb_top crb_checker #(.ADDR_W(ADDR_W)) crb_checker_inst (.*);

// [bench/crb_partner.sv]
// Acceptance filter and buffer write model
`timescale 1ns/10ps
module crb_partner (
  input wire logic clk,
  output logic hit_valid = 1'b0,
  output logic [1:0] hit_filter = 2'h0,
  output logic buf_wr_req = 1'b0,
  output logic [4:0] buf_wr_idx = 5'h00,
  output logic [31:0] buf_full = 32'h0
);
  task hit(input logic [1:0] f);
    @(posedge clk);
    hit_valid <= 1'b1;
    hit_filter <= f;
    @(posedge clk);
    hit_valid <= 1'b0;
  endtask
  // A stored message leaves its buffer full
  task put(input logic [4:0] i);
    @(posedge clk);
    buf_wr_req <= 1'b1;
    buf_wr_idx <= i;
    @(posedge clk);
    buf_wr_req <= 1'b0;
    buf_full[i] <= 1'b1;
  endtask
endmodule

// [bench/crb_top_tb.sv]
// Bench for the routing and overflow block
`timescale 1ns/10ps
module crb_top_tb;
  logic clk = 1'b0, nrst = 1'b0, avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest, irq, route_valid, route_to_fifo;
  logic [4:0] avs_address = 5'h00;
  logic [3:0] avs_byteenable = 4'hF, route_buf;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, e;
  wire hit_valid, buf_wr_req;
  wire [1:0] hit_filter;
  wire [4:0] buf_wr_idx;
  wire [31:0] buf_full;
  int miscompares = 0, check_count = 0;
  crb_top crb_top_inst (
    .clk(clk),
    .nrst(nrst),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_byteenable(avs_byteenable),
    .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .hit_valid(hit_valid),
    .hit_filter(hit_filter),
    .route_valid(route_valid),
    .route_to_fifo(route_to_fifo),
    .route_buf(route_buf),
    .buf_wr_req(buf_wr_req),
    .buf_wr_idx(buf_wr_idx),
    .buf_full(buf_full),
    .irq(irq)
  );
  crb_partner crb_partner_inst (
    .clk(clk),
    .hit_valid(hit_valid),
    .hit_filter(hit_filter),
    .buf_wr_req(buf_wr_req),
    .buf_wr_idx(buf_wr_idx),
    .buf_full(buf_full)
  );
  always #5 clk = ~clk;
  task chk(input logic [31:0] g, input logic [31:0] x);
    check_count++;
    if (g !== x) begin
      $display("wrong value %0t got %h", $time, g);
      miscompares++;
    end
  endtask
  // Request held until waitrequest is sampled low; read compares against v
  task bus(input logic wr, input logic [4:0] a, input logic [31:0] v);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= v;
    avs_write <= wr;
    avs_read <= !wr;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    if (!wr) chk(avs_readdata, v);
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task end_of_test;
    $display("checks %0d wrong %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    #100000;
    miscompares++;
    end_of_test;
  end
  initial begin
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    bus(0, 5'h00, 32'h0);
    bus(0, 5'h04, 32'h0);
    bus(0, 5'h14, 32'h0);
    bus(1, 5'h00, 32'hFE30);
    bus(0, 5'h00, 32'hFE30);
    for (int f = 0; f < 4; f++) begin
      e = 32'hFE30 >> 4 * f & 32'hF;
      crb_partner_inst.hit(f[1:0]);
      @(negedge clk);
      chk({route_valid, route_to_fifo, route_buf}, e == 32'hF ? 32'h30 : e | 32'h20);
    end
    $display("routing test done");
    bus(1, 5'h10, 32'h1);
    crb_partner_inst.put(5'h03);
    crb_partner_inst.put(5'h03);
    bus(0, 5'h04, 32'h8);
    crb_partner_inst.put(5'h11);
    crb_partner_inst.put(5'h11);
    bus(0, 5'h08, 32'h2);
    chk(irq, 1'b1);
    bus(0, 5'h0C, 32'h3);
    @(negedge clk);
    chk(irq, 1'b0);
    bus(1, 5'h04, 32'hFFFF);
    bus(0, 5'h04, 32'h8);
    bus(1, 5'h04, 32'h0);
    bus(0, 5'h04, 32'h0);
    bus(1, 5'h10, 32'h2);
    fork
      bus(1, 5'h04, 32'h0);
      begin
        @(posedge clk);
        crb_partner_inst.put(5'h03);
      end
    join
    bus(0, 5'h04, 32'h8);
    chk(irq, 1'b0);
    $display("overflow test done");
    end_of_test;
  end
endmodule
